// ### hdl/eidp_alu.sv
// Combinational ALU for the extended instruction group
`timescale 1ns/1ps
`default_nettype none
module eidp_alu
  import eidp_pkg::*;
(
  // Operand and result bundle
  eidp_alu_if.alu a
);
  logic [8:0] diff;
  logic [4:0] lowDiff;
  logic [7:0] subOp;
  logic borrowIn;
  logic subAny;
  logic [7:0] dec;
  logic [7:0] inc;

  always_comb begin
    subOp = a.memIn;
    borrowIn = 1'b0;
    subAny = 1'b0;
    dec = a.memIn - ONE_BYTE;
    inc = a.memIn + ONE_BYTE;
    diff = 9'h000;
    lowDiff = 5'h00;
    a.result = a.memIn;
    a.writeAcc = 1'b0;
    a.writeMem = 1'b0;
    a.skip = 1'b0;
    a.flagMask = 6'h00;
    a.flagVal = 6'h00;
    if (a.op == OP_SUBTRACT_BORROW_ACC || a.op == OP_SUBTRACT_BORROW_MEM) begin
      borrowIn = ~a.carryIn;
    end
    diff = {1'b0, a.accIn} - {1'b0, subOp} - {8'h00, borrowIn};
    lowDiff = {1'b0, a.accIn[3:0]} - {1'b0, subOp[3:0]} - {4'h0, borrowIn};
    unique case (a.op)
      OP_FAR_MOVE_TO_ACC: begin
        a.result = a.memIn;
        a.writeAcc = 1'b1;
      end
      OP_FAR_MOVE_TO_MEM: begin
        a.result = a.accIn;
        a.writeMem = 1'b1;
      end
      OP_FAR_OR_TO_ACC: begin
        a.result = a.accIn | a.memIn;
        a.writeAcc = 1'b1;
        a.flagMask[FLAG_Z] = 1'b1;
      end
      OP_FAR_OR_TO_MEM: begin
        a.result = a.accIn | a.memIn;
        a.writeMem = 1'b1;
        a.flagMask[FLAG_Z] = 1'b1;
      end
      OP_ROTATE_LEFT_MEM: begin
        a.result = {a.memIn[6:0], a.memIn[7]};
        a.writeMem = 1'b1;
      end
      OP_ROTATE_LEFT_ACC: begin
        a.result = {a.memIn[6:0], a.memIn[7]};
        a.writeAcc = 1'b1;
      end
      OP_ROTATE_LEFT_THRU_CARRY_MEM, OP_ROTATE_LEFT_THRU_CARRY_ACC: begin
        a.result = {a.memIn[6:0], a.carryIn};
        a.writeMem = (a.op == OP_ROTATE_LEFT_THRU_CARRY_MEM);
        a.writeAcc = (a.op == OP_ROTATE_LEFT_THRU_CARRY_ACC);
        a.flagMask[FLAG_C] = 1'b1;
        a.flagVal[FLAG_C] = a.memIn[7];
      end
      OP_ROTATE_RIGHT_MEM: begin
        a.result = {a.memIn[0], a.memIn[7:1]};
        a.writeMem = 1'b1;
      end
      OP_ROTATE_RIGHT_ACC: begin
        a.result = {a.memIn[0], a.memIn[7:1]};
        a.writeAcc = 1'b1;
      end
      OP_ROTATE_RIGHT_THRU_CARRY_MEM, OP_ROTATE_RIGHT_THRU_CARRY_ACC: begin
        a.result = {a.carryIn, a.memIn[7:1]};
        a.writeMem = (a.op == OP_ROTATE_RIGHT_THRU_CARRY_MEM);
        a.writeAcc = (a.op == OP_ROTATE_RIGHT_THRU_CARRY_ACC);
        a.flagMask[FLAG_C] = 1'b1;
        a.flagVal[FLAG_C] = a.memIn[0];
      end
      OP_SUBTRACT_BORROW_ACC, OP_SUBTRACT_BORROW_MEM, OP_SUBTRACT_ACC, OP_SUBTRACT_MEM: begin
        subAny = 1'b1;
        a.result = diff[7:0];
        a.writeMem = (a.op == OP_SUBTRACT_BORROW_MEM) || (a.op == OP_SUBTRACT_MEM);
        a.writeAcc = ~a.writeMem;
      end
      OP_DECREMENT_SKIP_ZERO_MEM: begin
        a.result = dec;
        a.writeMem = 1'b1;
        a.skip = (dec == 8'h00);
      end
      OP_DECREMENT_SKIP_ZERO_ACC: begin
        a.result = dec;
        a.writeAcc = 1'b1;
        a.skip = (dec == 8'h00);
      end
      OP_INCREMENT_SKIP_ZERO_MEM: begin
        a.result = inc;
        a.writeMem = 1'b1;
        a.skip = (inc == 8'h00);
      end
      OP_INCREMENT_SKIP_ZERO_ACC: begin
        a.result = inc;
        a.writeAcc = 1'b1;
        a.skip = (inc == 8'h00);
      end
      OP_FORCE_ONES: begin
        a.result = ALL_ONES;
        a.writeMem = 1'b1;
      end
      OP_FORCE_BIT: begin
        a.result = a.memIn | (ONE_BYTE << a.bitSel);
        a.writeMem = 1'b1;
      end
      OP_SKIP_IF_NONZERO: begin
        a.result = a.memIn;
        a.writeMem = 1'b1;
        a.skip = (a.memIn != 8'h00);
      end
      OP_SKIP_IF_BIT_SET: begin
        a.skip = a.memIn[a.bitSel];
      end
      default: begin
        a.result = a.memIn;
      end
    endcase
    if (subAny) begin
      a.flagMask = 6'h3f;
      a.flagVal[FLAG_C] = ~diff[8];
      a.flagVal[FLAG_HC] = ~lowDiff[4];
      a.flagVal[FLAG_OV] = (a.accIn[7] ^ subOp[7]) & (a.accIn[7] ^ diff[7]);
      a.flagVal[FLAG_SC] = a.flagVal[FLAG_OV] ^ diff[7];
      a.flagVal[FLAG_CZ] = (diff[7:0] == 8'h00);
    end
    a.flagVal[FLAG_Z] = (a.result == 8'h00);
  end
endmodule // eidp_alu
`default_nettype wire

// ### hdl/eidp_pkg.sv
// Package of opcodes, flag layout and timing constants for the extended datapath
package eidp_pkg;
  localparam int DATA_W = 8;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [5:0] FLAGS_RESET = 6'h00;
  localparam logic [7:0] ALL_ONES = 8'hff;
  localparam logic [7:0] ONE_BYTE = 8'h01;
  // Flag positions in the status vector
  localparam int FLAG_C = 0;
  localparam int FLAG_HC = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_OV = 3;
  localparam int FLAG_SC = 4;
  localparam int FLAG_CZ = 5;
  // Skip timing in instruction cycles
  localparam int SKIP_CYCLES = 3;
  localparam logic [1:0] SKIP_DUMMY_CYCLES = 2'(SKIP_CYCLES - 2);

  typedef enum logic [4:0] {
    OP_NOP = 5'h00,
    OP_FAR_MOVE_TO_ACC = 5'h01,
    OP_FAR_MOVE_TO_MEM = 5'h02,
    OP_FAR_OR_TO_ACC = 5'h03,
    OP_FAR_OR_TO_MEM = 5'h04,
    OP_ROTATE_LEFT_MEM = 5'h05,
    OP_ROTATE_LEFT_ACC = 5'h06,
    OP_ROTATE_LEFT_THRU_CARRY_MEM = 5'h07,
    OP_ROTATE_LEFT_THRU_CARRY_ACC = 5'h08,
    OP_ROTATE_RIGHT_MEM = 5'h09,
    OP_ROTATE_RIGHT_ACC = 5'h0a,
    OP_ROTATE_RIGHT_THRU_CARRY_MEM = 5'h0b,
    OP_ROTATE_RIGHT_THRU_CARRY_ACC = 5'h0c,
    OP_SUBTRACT_BORROW_ACC = 5'h0d,
    OP_SUBTRACT_BORROW_MEM = 5'h0e,
    OP_SUBTRACT_ACC = 5'h0f,
    OP_SUBTRACT_MEM = 5'h10,
    OP_DECREMENT_SKIP_ZERO_MEM = 5'h11,
    OP_DECREMENT_SKIP_ZERO_ACC = 5'h12,
    OP_INCREMENT_SKIP_ZERO_MEM = 5'h13,
    OP_INCREMENT_SKIP_ZERO_ACC = 5'h14,
    OP_FORCE_ONES = 5'h15,
    OP_FORCE_BIT = 5'h16,
    OP_SKIP_IF_NONZERO = 5'h17,
    OP_SKIP_IF_BIT_SET = 5'h18
  } eidp_op_e;

  typedef enum logic [0:0] {
    ST_RUN = 1'b0,
    ST_DUMMY = 1'b1
  } eidp_state_e;
endpackage : eidp_pkg

// ### hdl/eidp_alu_if.sv
// Interface carrying operands and results between the control and the ALU
`timescale 1ns/1ps
`default_nettype none
interface eidp_alu_if;
  import eidp_pkg::*;
  eidp_op_e op;
  logic [7:0] accIn;
  logic [7:0] memIn;
  logic [2:0] bitSel;
  logic carryIn;
  logic [7:0] result;
  logic writeAcc;
  logic writeMem;
  logic skip;
  logic [5:0] flagMask;
  logic [5:0] flagVal;
  modport ctrl (output op, accIn, memIn, bitSel, carryIn,
    input result, writeAcc, writeMem, skip, flagMask, flagVal);
  modport alu (input op, accIn, memIn, bitSel, carryIn,
    output result, writeAcc, writeMem, skip, flagMask, flagVal);
endinterface : eidp_alu_if
`default_nettype wire

// ### hdl/eidp_top.sv
// Extended instruction datapath: accumulator, flags, memory port and skip timing
// Function
// - Far move to accumulator loads memory byte, flags untouched.
// - Far move to memory stores accumulator, flags untouched.
// - Or to accumulator: accumulator or memory into accumulator, only zero flag.
// - Or to memory: accumulator or memory into memory, only zero flag.
// - Plain rotate left, bit 7 into bit 0, no flags.
// - Accumulator rotate variants leave memory byte unchanged.
// - Rotate left through carry; carry gets old bit 7, only carry changes.
// - Plain rotate right, bit 0 into bit 7, no flags.
// - Rotate right through carry; carry gets old bit 0, only carry changes.
// - Subtract with borrow uses inverted carry, updates six flags.
// - Subtraction clears carry on negative, sets it otherwise.
// - Memory form of subtract with borrow writes memory, same flags.
// - Plain subtract ignores carry, either destination, six flags.
// - A taken skip takes three cycles with one dummy cycle.
// - Decrement memory, skip when new value is zero, no flags.
// - Decrement into accumulator, memory untouched, skip on zero.
// - Increment memory, skip when new value is zero, no flags.
// - Increment into accumulator, memory untouched, skip on zero.
// - Force ones writes all ones to memory, no flags.
// - Force bit sets selected bit only, no flags.
// - Skip if nonzero rewrites byte, skips when nonzero.
// - Bit test skips when selected bit is one.
`timescale 1ns/1ps
`default_nettype none
module eidp_top
  import eidp_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Decoder request
  input wire logic instValid,
  input wire eidp_op_e instOp,
  input wire logic [2:0] instBit,
  // Data memory read
  input wire logic [7:0] memRdata,
  // Data memory write
  output logic memWe,
  output logic [7:0] memWdata,
  // Core state
  output logic [7:0] acc,
  output logic [5:0] flags,
  // Pipeline control
  output logic instReady,
  output logic dummySlot,
  output logic skipTaken
);
  eidp_alu_if aluBus ();
  eidp_state_e state;
  eidp_state_e next_state;
  logic [1:0] dummyCnt;
  logic [1:0] next_dummyCnt;
  logic [7:0] next_acc;
  logic [5:0] next_flags;
  logic next_memWe;
  logic [7:0] next_memWdata;
  logic next_skipTaken;
  logic issue;

  eidp_alu u_alu (
    .a(aluBus.alu)
  );

  assign aluBus.op = instOp;
  assign aluBus.accIn = acc;
  assign aluBus.memIn = memRdata;
  assign aluBus.bitSel = instBit;
  assign aluBus.carryIn = flags[FLAG_C];
  // Decoder must hold off while the dummy slot runs
  assign instReady = (state == ST_RUN);
  assign dummySlot = (state == ST_DUMMY);
  assign issue = instValid && instReady;

  always_comb begin
    next_acc = acc;
    next_flags = flags;
    next_memWe = 1'b0;
    next_memWdata = memWdata;
    next_skipTaken = 1'b0;
    next_state = state;
    next_dummyCnt = dummyCnt;
    unique case (state)
      ST_RUN: begin
        if (issue) begin
          if (aluBus.writeAcc) begin
            next_acc = aluBus.result;
          end
          if (aluBus.writeMem) begin
            next_memWe = 1'b1;
            next_memWdata = aluBus.result;
          end
          // Only masked flags move; others hold
          next_flags = (flags & ~aluBus.flagMask) | (aluBus.flagVal & aluBus.flagMask);
          if (aluBus.skip) begin
            next_skipTaken = 1'b1;
            next_state = ST_DUMMY;
            next_dummyCnt = SKIP_DUMMY_CYCLES;
          end
        end
      end
      ST_DUMMY: begin
        next_dummyCnt = dummyCnt - 2'd1;
        if (dummyCnt == 2'd1) begin
          next_state = ST_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state <= ST_RUN;
      dummyCnt <= 2'd0;
      acc <= ACC_RESET;
      flags <= FLAGS_RESET;
      memWe <= 1'b0;
      memWdata <= 8'h00;
      skipTaken <= 1'b0;
    end else begin
      state <= next_state;
      dummyCnt <= next_dummyCnt;
      acc <= next_acc;
      flags <= next_flags;
      memWe <= next_memWe;
      memWdata <= next_memWdata;
      skipTaken <= next_skipTaken;
    end
  end
endmodule // eidp_top
`default_nettype wire

// ### sim/eidp_chk.sv
// Checker for the extended datapath ports
`timescale 1ns/1ps
`default_nettype none
module eidp_chk
  import eidp_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Decoder request
  input wire logic instValid,
  input wire eidp_op_e instOp,
  input wire logic [2:0] instBit,
  input wire logic [7:0] memRdata,
  // Design outputs
  input wire logic memWe,
  input wire logic [7:0] memWdata,
  input wire logic [7:0] acc,
  input wire logic [5:0] flags,
  input wire logic instReady,
  input wire logic dummySlot,
  input wire logic skipTaken
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  logic go;
  logic [7:0] pm;
  logic [7:0] pa;
  logic pc;
  assign go = instValid && instReady;
  // Operands of the previous cycle, sliced freely below
  always_ff @(posedge core_clk) begin
    pm <= memRdata;
    pa <= acc;
    pc <= flags[FLAG_C];
  end
  a_move_acc_load: assert property (go && instOp == OP_FAR_MOVE_TO_ACC |=>
    acc == pm && $stable(flags)) else $error("move to acc wrong");
  a_move_mem_store: assert property (go && instOp == OP_FAR_MOVE_TO_MEM |=>
    memWe && memWdata == pa && $stable(flags)) else $error("move to mem wrong");
  a_or_acc_zero: assert property (go && instOp == OP_FAR_OR_TO_ACC |=>
    acc == (pa | pm) && flags[FLAG_Z] == (acc == 8'h00)) else $error("or to acc wrong");
  a_rotate_acc_only: assert property (go && instOp == OP_ROTATE_LEFT_ACC |=>
    acc == {pm[6:0], pm[7]} && !memWe) else $error("rotate to acc wrong");
  a_rotate_carry_in: assert property (go && instOp == OP_ROTATE_LEFT_THRU_CARRY_MEM |=>
    memWdata == {pm[6:0], pc} && flags[FLAG_C] == pm[7]) else $error("carry rotate wrong");
  a_sub_carry_sign: assert property (go && instOp == OP_SUBTRACT_ACC |=>
    flags[FLAG_C] == (pa >= pm) && acc == pa - pm) else $error("subtract carry wrong");
  a_skip_dummy_slot: assert property (skipTaken |->
    dummySlot && !instReady ##1 !dummySlot && instReady) else $error("skip timing wrong");
  a_dummy_refuses: assert property (dummySlot |=>
    !memWe && !skipTaken && $stable(acc)) else $error("dummy cycle not idle");
  a_dec_skip_zero: assert property (go && instOp == OP_DECREMENT_SKIP_ZERO_MEM |=>
    memWdata == pm - 8'h01 && skipTaken == (pm == 8'h01)) else $error("decrement skip wrong");
  a_force_all_ones: assert property (go && instOp == OP_FORCE_ONES |=>
    memWe && memWdata == ALL_ONES && $stable(flags)) else $error("force ones wrong");
  c_skip: cover property (skipTaken);
  c_refused: cover property (dummySlot && instValid);
  c_borrow: cover property (go && instOp == OP_SUBTRACT_BORROW_MEM);
endmodule // eidp_chk
bind eidp_top eidp_chk u_chk (.core_clk, .srst, .instValid, .instOp, .instBit, .memRdata,
  .memWe, .memWdata, .acc, .flags, .instReady, .dummySlot, .skipTaken);
`default_nettype wire

// ### sim/testbench.sv
// Self-checking bench for the extended datapath
`timescale 1ns/1ps
`default_nettype none
module testbench
  import eidp_pkg::*;
;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic instValid = 1'b0;
  eidp_op_e instOp = OP_NOP;
  logic [2:0] instBit = 3'h0;
  logic [7:0] memRdata = 8'h00;
  logic memWe, instReady, dummySlot, skipTaken;
  logic [7:0] memWdata, acc;
  logic [5:0] flags;
  logic [7:0] eAcc = ACC_RESET;
  logic [5:0] eFlg = FLAGS_RESET;
  int err_count = 0;
  int checks_done = 0;

  eidp_top DUT (.core_clk, .srst, .instValid, .instOp, .instBit, .memRdata, .memWe,
    .memWdata, .acc, .flags, .instReady, .dummySlot, .skipTaken);

  always #12.5 core_clk = ~core_clk;

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Destination: 0 none, 1 accumulator, 2 memory
  task automatic run(input eidp_op_e op, input logic [2:0] b, input logic [7:0] m,
      input int dst);
    logic [7:0] r;
    logic [8:0] d;
    logic [4:0] h;
    logic bw, s, ov, c;
    c = eFlg[FLAG_C];
    bw = (op inside {OP_SUBTRACT_BORROW_ACC, OP_SUBTRACT_BORROW_MEM}) ? ~c : 1'b0;
    d = {1'b0, eAcc} - {1'b0, m} - 9'(bw);
    h = {1'b0, eAcc[3:0]} - {1'b0, m[3:0]} - 5'(bw);
    case (op)
      OP_FAR_MOVE_TO_MEM: r = eAcc;
      OP_FAR_OR_TO_ACC, OP_FAR_OR_TO_MEM: r = eAcc | m;
      OP_ROTATE_LEFT_MEM, OP_ROTATE_LEFT_ACC: r = {m[6:0], m[7]};
      OP_ROTATE_LEFT_THRU_CARRY_MEM, OP_ROTATE_LEFT_THRU_CARRY_ACC: r = {m[6:0], c};
      OP_ROTATE_RIGHT_MEM, OP_ROTATE_RIGHT_ACC: r = {m[0], m[7:1]};
      OP_ROTATE_RIGHT_THRU_CARRY_MEM, OP_ROTATE_RIGHT_THRU_CARRY_ACC: r = {c, m[7:1]};
      OP_SUBTRACT_BORROW_ACC, OP_SUBTRACT_BORROW_MEM, OP_SUBTRACT_ACC,
          OP_SUBTRACT_MEM: r = d[7:0];
      OP_DECREMENT_SKIP_ZERO_MEM, OP_DECREMENT_SKIP_ZERO_ACC: r = m - 8'h01;
      OP_INCREMENT_SKIP_ZERO_MEM, OP_INCREMENT_SKIP_ZERO_ACC: r = m + 8'h01;
      OP_FORCE_ONES: r = ALL_ONES;
      OP_FORCE_BIT: r = m | (8'h01 << b);
      default: r = m;
    endcase
    ov = (eAcc[7] ^ m[7]) & (r[7] ^ eAcc[7]);
    case (op)
      OP_DECREMENT_SKIP_ZERO_MEM, OP_DECREMENT_SKIP_ZERO_ACC, OP_INCREMENT_SKIP_ZERO_MEM,
          OP_INCREMENT_SKIP_ZERO_ACC: s = (r == 8'h00);
      OP_SKIP_IF_NONZERO: s = (m != 8'h00);
      OP_SKIP_IF_BIT_SET: s = m[b];
      default: s = 1'b0;
    endcase
    if (op inside {OP_ROTATE_LEFT_THRU_CARRY_MEM, OP_ROTATE_LEFT_THRU_CARRY_ACC})
      eFlg[FLAG_C] = m[7];
    if (op inside {OP_ROTATE_RIGHT_THRU_CARRY_MEM, OP_ROTATE_RIGHT_THRU_CARRY_ACC})
      eFlg[FLAG_C] = m[0];
    if (op inside {OP_FAR_OR_TO_ACC, OP_FAR_OR_TO_MEM})
      eFlg[FLAG_Z] = (r == 8'h00);
    if (op inside {OP_SUBTRACT_BORROW_ACC, OP_SUBTRACT_BORROW_MEM, OP_SUBTRACT_ACC,
        OP_SUBTRACT_MEM})
      eFlg = {r == 8'h00, ov ^ r[7], ov, r == 8'h00, ~h[4], ~d[8]};
    if (dst == 1)
      eAcc = r;
    @(negedge core_clk);
    instValid = 1'b1;
    instOp = op;
    instBit = b;
    memRdata = m;
    @(negedge core_clk);
    // Keep a request up in the dummy slot: it must be ignored
    instValid = s;
    instOp = OP_FORCE_ONES;
    chk(acc, eAcc);
    chk(flags, eFlg);
    chk(memWe, dst == 2);
    if (dst == 2)
      chk(memWdata, r);
    chk(skipTaken, s);
    chk(dummySlot, s);
    if (s) begin
      @(negedge core_clk);
      instValid = 1'b0;
      chk(memWe, 1'b0);
      chk(instReady, 1'b1);
    end
  endtask

  task automatic t_move_or();
    run(OP_FAR_MOVE_TO_ACC, 3'h0, 8'ha5, 1);
    run(OP_FAR_MOVE_TO_MEM, 3'h0, 8'h3c, 2);
    run(OP_FAR_MOVE_TO_ACC, 3'h0, 8'h00, 1);
    run(OP_FAR_OR_TO_ACC, 3'h0, 8'h00, 1);
    run(OP_FAR_OR_TO_MEM, 3'h0, 8'h30, 2);
  endtask

  task automatic t_rotate();
    run(OP_ROTATE_LEFT_MEM, 3'h0, 8'h81, 2);
    run(OP_ROTATE_LEFT_ACC, 3'h0, 8'h81, 1);
    run(OP_ROTATE_LEFT_THRU_CARRY_MEM, 3'h0, 8'h80, 2);
    run(OP_ROTATE_LEFT_THRU_CARRY_ACC, 3'h0, 8'h01, 1);
    run(OP_ROTATE_RIGHT_MEM, 3'h0, 8'h01, 2);
    run(OP_ROTATE_RIGHT_ACC, 3'h0, 8'h01, 1);
    run(OP_ROTATE_RIGHT_THRU_CARRY_MEM, 3'h0, 8'h01, 2);
    run(OP_ROTATE_RIGHT_THRU_CARRY_ACC, 3'h0, 8'h80, 1);
  endtask

  task automatic t_sub();
    run(OP_FAR_MOVE_TO_ACC, 3'h0, 8'h05, 1);
    run(OP_SUBTRACT_ACC, 3'h0, 8'h03, 1);
    run(OP_SUBTRACT_MEM, 3'h0, 8'h05, 2);
    run(OP_SUBTRACT_BORROW_ACC, 3'h0, 8'h02, 1);
    run(OP_SUBTRACT_BORROW_MEM, 3'h0, 8'h7f, 2);
    run(OP_SUBTRACT_BORROW_ACC, 3'h0, 8'h00, 1);
    run(OP_FAR_MOVE_TO_ACC, 3'h0, 8'h80, 1);
    run(OP_SUBTRACT_ACC, 3'h0, 8'h80, 1);
  endtask

  // Two issues on adjacent edges; second must see the first's accumulator
  task automatic t_back_to_back();
    @(negedge core_clk);
    instValid = 1'b1;
    instOp = OP_FAR_MOVE_TO_ACC;
    instBit = 3'h0;
    memRdata = 8'h11;
    @(negedge core_clk);
    instOp = OP_FAR_OR_TO_ACC;
    memRdata = 8'h22;
    chk(acc, 8'h11);
    @(negedge core_clk);
    instValid = 1'b0;
    eAcc = 8'h33;
    eFlg[FLAG_Z] = 1'b0;
    chk(acc, eAcc);
    chk(flags, eFlg);
  endtask

  // Reset in mid-run with a nonzero accumulator
  task automatic t_reset();
    @(negedge core_clk);
    srst = 1'b1;
    repeat (2) @(negedge core_clk);
    srst = 1'b0;
    eAcc = ACC_RESET;
    eFlg = FLAGS_RESET;
    chk(acc, ACC_RESET);
    chk(flags, FLAGS_RESET);
    chk(memWe, 1'b0);
    chk(skipTaken, 1'b0);
    chk(instReady, 1'b1);
    chk(dummySlot, 1'b0);
    run(OP_FAR_OR_TO_ACC, 3'h0, 8'h00, 1);
  endtask

  task automatic t_skip_set();
    run(OP_DECREMENT_SKIP_ZERO_MEM, 3'h0, 8'h01, 2);
    run(OP_DECREMENT_SKIP_ZERO_MEM, 3'h0, 8'h05, 2);
    run(OP_DECREMENT_SKIP_ZERO_ACC, 3'h0, 8'h01, 1);
    run(OP_INCREMENT_SKIP_ZERO_MEM, 3'h0, 8'hff, 2);
    run(OP_INCREMENT_SKIP_ZERO_ACC, 3'h0, 8'hff, 1);
    run(OP_INCREMENT_SKIP_ZERO_ACC, 3'h0, 8'h05, 1);
    run(OP_SKIP_IF_NONZERO, 3'h0, 8'h00, 2);
    run(OP_SKIP_IF_NONZERO, 3'h0, 8'h5a, 2);
    run(OP_SKIP_IF_BIT_SET, 3'h3, 8'h08, 0);
    run(OP_SKIP_IF_BIT_SET, 3'h3, 8'hf7, 0);
    run(OP_FORCE_ONES, 3'h0, 8'h12, 2);
    run(OP_FORCE_BIT, 3'h7, 8'h00, 2);
    run(OP_FORCE_BIT, 3'h0, 8'h10, 2);
  endtask

  task automatic give_verdict();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge core_clk);
    @(negedge core_clk);
    srst = 1'b0;
    chk(acc, ACC_RESET);
    chk(flags, FLAGS_RESET);
    t_move_or();
    t_rotate();
    t_sub();
    t_skip_set();
    t_back_to_back();
    t_reset();
    give_verdict();
  end

  // About 90 cycles of traffic; generous margin
  initial begin
    repeat (2000) @(posedge core_clk);
    err_count++;
    give_verdict();
  end
endmodule // testbench
`default_nettype wire
